// ===== design/pmcs_top.sv
`timescale 1ns/100ps
// What this block does
// - Standby wake waits 8192..131072, 1024, 128 or 16 states per wait code.
// - Sleep instruction picks next mode from sleep, low speed, direct, standby bits.
// - Divider code 0xx undivided, 100 /8, 101 /16, 110 /32, 111 /64.
// - Writing the divider code takes effect only at the next sleep instruction.
// - Reset clears mode bits and divider code, so start is undivided.
module pmcs_top #(
  parameter logic [7:0][17:0] WAIT_TABLE = pmcs_pkg::WAIT_TABLE_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sleepExec,
  input wire logic wakeReq,
  input wire logic subTick,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic oscRun,
  output logic [2:0] powerMode,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  function automatic logic [6:0] divPeriod(input logic [2:0] code);
    case (code)
      3'b100: divPeriod = pmcs_pkg::DIV_PERIOD_8;
      3'b101: divPeriod = pmcs_pkg::DIV_PERIOD_16;
      3'b110: divPeriod = pmcs_pkg::DIV_PERIOD_32;
      3'b111: divPeriod = pmcs_pkg::DIV_PERIOD_64;
      default: divPeriod = pmcs_pkg::DIV_PERIOD_1;
    endcase
  endfunction
  function automatic pmcs_pkg::pmcs_mode_t decide(
      input pmcs_pkg::pmcs_ctrl1_t c1, input pmcs_pkg::pmcs_ctrl2_t c2);
    if (c2.directXfer) begin
      decide = c2.lowSpeed ? pmcs_pkg::PM_SUBACTIVE : pmcs_pkg::PM_ACTIVE;
    end else if (c1.standby) begin
      decide = pmcs_pkg::PM_STANDBY;
    end else if (c2.lowSpeed || c2.sleepMode) begin
      decide = pmcs_pkg::PM_SUBSLEEP;
    end else begin
      decide = pmcs_pkg::PM_SLEEP;
    end
  endfunction
  // ****************************************
  // Register bus
  // ****************************************
  pmcs_pkg::pmcs_ctrl1_t ctrl1;
  pmcs_pkg::pmcs_ctrl2_t ctrl2;
  logic [2:0] activeDiv;
  pmcs_pkg::pmcs_mode_t state;
  logic [3:0] wAddr;
  logic [7:0] wByte;
  logic haveAw, haveW, wrFire, wrLane;
  logic [31:0] readWord;
  // Address and data may arrive in either order; each is parked until both
  assign wrFire = haveAw && haveW && !s_axi_bvalid;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      wrLane <= 1'b0;
      wAddr <= 4'h0;
      wByte <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmcs_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !haveW && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        wAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW <= 1'b1;
        wByte <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        wrLane <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wAddr == pmcs_pkg::ADDR_CTRL1 ||
          wAddr == pmcs_pkg::ADDR_CTRL2) ? pmcs_pkg::RESP_OKAY :
          pmcs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Register storage; writes with byte lane 0 off leave the value alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1 <= pmcs_pkg::CTRL1_RESET;
      ctrl2 <= pmcs_pkg::CTRL2_RESET;
    end else if (wrFire && wrLane) begin
      if (wAddr == pmcs_pkg::ADDR_CTRL1) begin
        ctrl1 <= {wByte[pmcs_pkg::CTRL1_STBY_BIT],
          wByte[pmcs_pkg::CTRL1_WAIT_LSB +: 3]};
      end
      if (wAddr == pmcs_pkg::ADDR_CTRL2) begin
        ctrl2 <= {wByte[pmcs_pkg::CTRL2_SLEEP_MODE_SELECT_BIT],
          wByte[pmcs_pkg::CTRL2_LOW_SPEED_ENABLE_BIT], wByte[pmcs_pkg::CTRL2_DIRECT_TRANSFER_ENABLE_BIT],
          wByte[pmcs_pkg::CTRL2_DIV_LSB +: 3]};
      end
    end
  end
  always_comb begin
    readWord = 32'h0000_0000;
    case (s_axi_araddr)
      pmcs_pkg::ADDR_CTRL1: begin
        readWord[pmcs_pkg::CTRL1_STBY_BIT] = ctrl1.standby;
        readWord[pmcs_pkg::CTRL1_WAIT_LSB +: 3] = ctrl1.waitSel;
      end
      pmcs_pkg::ADDR_CTRL2: begin
        readWord[7:2] = ctrl2;
      end
      pmcs_pkg::ADDR_STATUS: begin
        readWord[2:0] = state;
        readWord[pmcs_pkg::STAT_DIV_LSB +: 3] = activeDiv;
        readWord[pmcs_pkg::STAT_SETTLE_BIT] = (state == pmcs_pkg::PM_SETTLE);
      end
      default: readWord = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pmcs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= (s_axi_araddr == pmcs_pkg::ADDR_CTRL1 ||
          s_axi_araddr == pmcs_pkg::ADDR_CTRL2 ||
          s_axi_araddr == pmcs_pkg::ADDR_STATUS) ? pmcs_pkg::RESP_OKAY :
          pmcs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // Power mode sequencer
  // ****************************************
  logic [17:0] settleCnt, waitLen;
  logic sleepTake;
  assign sleepTake = sleepExec && (state == pmcs_pkg::PM_ACTIVE ||
    state == pmcs_pkg::PM_SUBACTIVE);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= pmcs_pkg::PM_ACTIVE;
    end else begin
      case (state)
        pmcs_pkg::PM_ACTIVE, pmcs_pkg::PM_SUBACTIVE: begin
          if (sleepTake) begin
            state <= decide(ctrl1, ctrl2);
          end
        end
        pmcs_pkg::PM_SLEEP: begin
          if (wakeReq) state <= pmcs_pkg::PM_ACTIVE;
        end
        pmcs_pkg::PM_SUBSLEEP: begin
          if (wakeReq) state <= pmcs_pkg::PM_SUBACTIVE;
        end
        pmcs_pkg::PM_STANDBY: begin
          if (wakeReq) state <= pmcs_pkg::PM_SETTLE;
        end
        pmcs_pkg::PM_SETTLE: begin
          if (settleCnt == waitLen - 18'h0_0001) begin
            state <= pmcs_pkg::PM_ACTIVE;
          end
        end
        default: state <= pmcs_pkg::PM_ACTIVE;
      endcase
    end
  end
  // Wait length is frozen on entry so a rewrite cannot stretch a wait
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settleCnt <= 18'h0_0000;
      waitLen <= 18'h0_0010;
    end else if (state == pmcs_pkg::PM_STANDBY) begin
      settleCnt <= 18'h0_0000;
      waitLen <= WAIT_TABLE[ctrl1.waitSel];
    end else if (state == pmcs_pkg::PM_SETTLE) begin
      settleCnt <= settleCnt + 18'h0_0001;
    end
  end
  // New divider code is applied only as a sleep instruction executes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activeDiv <= 3'h0;
    end else if (sleepTake) begin
      activeDiv <= ctrl2.clkDiv;
    end
  end
  // ****************************************
  // Clock enables
  // ****************************************
  logic [6:0] divCnt;
  logic divTick;
  assign divTick = (divCnt >= divPeriod(activeDiv) - 7'h01);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCnt <= 7'h00;
    end else begin
      divCnt <= divTick ? 7'h00 : divCnt + 7'h01;
    end
  end
  // Subactive runs off the slow tick; CPU is gated while settling
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpuClkEn <= 1'b0;
      periphClkEn <= 1'b0;
      oscRun <= 1'b1;
      powerMode <= 3'h0;
    end else begin
      cpuClkEn <= (state == pmcs_pkg::PM_ACTIVE && divTick) ||
        (state == pmcs_pkg::PM_SUBACTIVE && subTick);
      periphClkEn <= ((state == pmcs_pkg::PM_ACTIVE ||
        state == pmcs_pkg::PM_SLEEP) && divTick) ||
        ((state == pmcs_pkg::PM_SUBACTIVE ||
        state == pmcs_pkg::PM_SUBSLEEP) && subTick);
      oscRun <= (state != pmcs_pkg::PM_STANDBY);
      powerMode <= state;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  logic [17:0] settleSeen;
  logic [6:0] gapCnt;
  logic gapArm;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settleSeen <= 18'h0_0000;
      gapCnt <= 7'h00;
      gapArm <= 1'b0;
    end else begin
      settleSeen <= (state == pmcs_pkg::PM_SETTLE) ?
        settleSeen + 18'h0_0001 : 18'h0_0000;
      gapCnt <= (divTick || state != pmcs_pkg::PM_ACTIVE) ?
        7'h00 : gapCnt + 7'h01;
      // First gap after entering active or a divider change is partial
      gapArm <= state == pmcs_pkg::PM_ACTIVE && !sleepTake &&
        (gapArm || divTick);
    end
  end
  sequence seqSettleEnd;
    state == pmcs_pkg::PM_SETTLE ##1 state == pmcs_pkg::PM_ACTIVE;
  endsequence
  a_wait_length: assert property (@(posedge clk) disable iff (!resetn)
    seqSettleEnd |-> $past(settleSeen) + 18'h0_0001 == waitLen)
    else $error("settling wait length wrong");
  a_mode_choice: assert property (@(posedge clk) disable iff (!resetn)
    sleepTake |=> (state == pmcs_pkg::PM_STANDBY) ==
    ($past(ctrl1.standby) && !$past(ctrl2.directXfer)))
    else $error("wrong mode after sleep");
  a_mode_direct: assert property (@(posedge clk) disable iff (!resetn)
    sleepTake && ctrl2.directXfer |=> state == ($past(ctrl2.lowSpeed) ?
    pmcs_pkg::PM_SUBACTIVE : pmcs_pkg::PM_ACTIVE))
    else $error("wrong mode after direct transfer");
  a_div_rate: assert property (@(posedge clk) disable iff (!resetn)
    (state == pmcs_pkg::PM_ACTIVE && divTick && gapArm &&
    $stable(activeDiv)) |-> gapCnt + 7'h01 == divPeriod(activeDiv))
    else $error("divider period wrong");
  a_div_hold: assert property (@(posedge clk) disable iff (!resetn)
    $changed(activeDiv) |-> $past(sleepTake))
    else $error("divider changed without sleep");
  a_reset_clear: assert property (@(posedge clk) disable iff (!resetn)
    !$past(resetn) |-> ctrl2 == 6'h00 && activeDiv == 3'h0)
    else $error("bad reset values");
  a_settle_gate: assert property (@(posedge clk) disable iff (!resetn)
    state == pmcs_pkg::PM_SETTLE |=> !cpuClkEn && oscRun)
    else $error("cpu clock not gated while settling");
endmodule // pmcs_top

// ===== design/pmcs_pkg.sv
package pmcs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL1_STBY_BIT = 7;
  localparam int CTRL1_WAIT_LSB = 4;
  localparam int CTRL2_SLEEP_MODE_SELECT_BIT = 7;
  localparam int CTRL2_LOW_SPEED_ENABLE_BIT = 6;
  localparam int CTRL2_DIRECT_TRANSFER_ENABLE_BIT = 5;
  localparam int CTRL2_DIV_LSB = 2;
  localparam int STAT_DIV_LSB = 4;
  localparam int STAT_SETTLE_BIT = 7;
  localparam logic [3:0] CTRL1_RESET = 4'h0;
  localparam logic [5:0] CTRL2_RESET = 6'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int WAIT_W = 18;
  localparam logic [7:0][WAIT_W-1:0] WAIT_TABLE_DEFAULT = {
    18'h0_0010, 18'h0_0080, 18'h0_0400, 18'h2_0000,
    18'h1_0000, 18'h0_8000, 18'h0_4000, 18'h0_2000};
  localparam logic [6:0] DIV_PERIOD_1 = 7'h01;
  localparam logic [6:0] DIV_PERIOD_8 = 7'h08;
  localparam logic [6:0] DIV_PERIOD_16 = 7'h10;
  localparam logic [6:0] DIV_PERIOD_32 = 7'h20;
  localparam logic [6:0] DIV_PERIOD_64 = 7'h40;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PM_ACTIVE, PM_SLEEP, PM_SUBSLEEP, PM_STANDBY, PM_SETTLE, PM_SUBACTIVE
  } pmcs_mode_t;

  typedef struct packed {
    logic standby;
    logic [2:0] waitSel;
  } pmcs_ctrl1_t;

  typedef struct packed {
    logic sleepMode;
    logic lowSpeed;
    logic directXfer;
    logic [2:0] clkDiv;
  } pmcs_ctrl2_t;

endpackage

// ===== tb/pmcs_top_tb.sv
`timescale 1ns/100ps
module pmcs_top_tb;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  // Short distinct waits so a wrong table index is seen
  localparam logic [7:0][17:0] WT = {18'h0_0029, 18'h0_0026,
    18'h0_0023, 18'h0_0020, 18'h0_001D, 18'h0_001A, 18'h0_0017,
    18'h0_0014};
  localparam logic [3:0] A1 = pmcs_pkg::ADDR_CTRL1;
  localparam logic [3:0] A2 = pmcs_pkg::ADDR_CTRL2;
  localparam logic [3:0] AS = pmcs_pkg::ADDR_STATUS;
  logic clk = 1'b0, resetn = 1'b0, sleepExec = 1'b0, wakeReq = 1'b0;
  logic subTick = 1'b0, cpuClkEn, periphClkEn, oscRun;
  logic [2:0] powerMode;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  logic [14:0] steps [6];
  logic [2:0] codes [5];
  int pers [5];
  int n_mismatch = 0, checked = 0, p, prev, n, bad, k;

  pmcs_top #(.WAIT_TABLE(WT)) u_dut (.clk, .resetn, .sleepExec,
    .wakeReq, .subTick, .cpuClkEn, .periphClkEn, .oscRun, .powerMode,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  always #5 clk = ~clk;
  // Subclock ticks keep the slow-mode logic exercised
  always @(posedge clk) subTick <= ~subTick;

  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo();
    n_mismatch++;
    $display("[ERR] wait expected done seen timeout");
    report_and_stop();
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Cycles between two CPU clock enables
  task automatic period();
    int i;
    for (i = 0; i < 200 && cpuClkEn !== 1'b1; i++) @(posedge clk);
    if (i == 200) tmo();
    @(posedge clk);
    for (p = 1; p < 200 && cpuClkEn !== 1'b1; p++) @(posedge clk);
  endtask

  task automatic pulse(input bit wake, input int gap);
    @(posedge clk);
    if (wake) wakeReq <= 1'b1;
    else sleepExec <= 1'b1;
    @(posedge clk);
    wakeReq <= 1'b0;
    sleepExec <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  initial begin
    steps = '{{8'h00, 1'b1, 3'd1, 3'd0}, {8'h80, 1'b1, 3'd2, 3'd5},
      {8'h20, 1'b0, 3'd0, 3'd0}, {8'h60, 1'b0, 3'd5, 3'd5},
      {8'h40, 1'b1, 3'd2, 3'd5}, {8'h20, 1'b0, 3'd0, 3'd0}};
    codes = '{3'b100, 3'b101, 3'b110, 3'b111, 3'b011};
    pers = '{8, 16, 32, 64, 1};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(A2);
    chk("ctrl2 reset", 0, d);
    rd(AS);
    chk("status reset", 0, d);
    period();
    chk("reset period", 1, p);
    wr(A2, 8'hFF);
    rd(A2);
    chk("ctrl2 readback", 32'h0000_00FC, d);
    rd(AS);
    chk("divider unchanged", 0, d[6:4]);
    wr(A2, 8'h00);
    wr(4'hC, 8'h55);
    chk("unmapped bresp", pmcs_pkg::RESP_SLVERR, r);
    rd(4'hC);
    chk("unmapped rresp", pmcs_pkg::RESP_SLVERR, r);
    chk("unmapped rdata", 0, d);
    // Mode choice, including waking from the slow modes
    for (int i = 0; i < 6; i++) begin
      wr(A2, steps[i][14:7]);
      pulse(0, 3);
      chk("sleep mode", steps[i][5:3], powerMode);
      if (steps[i][5:3] == 3'd1) begin
        chk("periph in sleep", 1, periphClkEn);
        chk("cpu in sleep", 0, cpuClkEn);
      end
      if (steps[i][6]) begin
        pulse(1, 3);
        chk("wake mode", steps[i][2:0], powerMode);
      end
    end
    // New divider only after the next sleep instruction
    prev = 1;
    for (int i = 0; i < 5; i++) begin
      wr(A2, {3'b000, codes[i], 2'b00});
      period();
      chk("period before sleep", prev, p);
      pulse(0, 3);
      pulse(1, 3);
      rd(AS);
      chk("divider in effect", codes[i], d[6:4]);
      period();
      chk("divider period", pers[i], p);
      prev = pers[i];
    end
    // Every settling wait code, CPU gated throughout
    for (int w = 0; w < 8; w++) begin
      wr(A1, {1'b1, w[2:0], 4'h0});
      pulse(0, 3);
      chk("standby mode", 3, powerMode);
      chk("osc stopped", 0, oscRun);
      pulse(1, 0);
      for (k = 0; k < 20 && powerMode !== 3'd4; k++) @(posedge clk);
      n = 0;
      bad = 0;
      for (k = 0; k < 200 && powerMode === 3'd4; k++) begin
        n++;
        if (cpuClkEn !== 1'b0) bad++;
        @(posedge clk);
      end
      chk("settle length", WT[w], n);
      chk("cpu gated", 0, bad);
      chk("osc running", 1, oscRun);
    end
    report_and_stop();
  end
endmodule // pmcs_top_tb
